/* verilog/fpt_pkg.sv */
// Constants and carrier types for the flash parameter table ROM.
// Assumes one system clock shared with the serial command engine.
package fpt_pkg;

  localparam int unsigned FPT_AW = 8;
  localparam logic [FPT_AW-1:0] FPT_TOP_ADDR = 8'hff;
  localparam logic [FPT_AW-1:0] FPT_BASE_ADDR = 8'h30;
  localparam logic [FPT_AW-1:0] FPT_LAST_ADDR = 8'h53;
  localparam logic [7:0] FPT_BLANK = 8'hff;
  localparam logic [2:0] FPT_BIT_FIRST = 3'h7;
  localparam logic [2:0] FPT_BIT_LAST = 3'h0;

  // Byte 30H fields
  localparam logic [1:0] FPT_ERASE4K_CODE = 2'h1;
  localparam logic FPT_WRITE_GRAN = 1'b1;
  localparam logic FPT_VOL_STATUS = 1'b0;
  localparam logic FPT_VOL_WREN_SEL = 1'b0;
  localparam logic [2:0] FPT_UNUSED_30 = 3'h7;
  // Byte 32H fields
  localparam logic FPT_SUP_112 = 1'b1;
  localparam logic [1:0] FPT_ADDR_BYTES = 2'h0;
  localparam logic FPT_SUP_DTR = 1'b0;
  localparam logic FPT_SUP_122 = 1'b1;
  localparam logic FPT_SUP_144 = 1'b1;
  localparam logic FPT_SUP_114 = 1'b1;
  localparam logic FPT_UNUSED_32 = 1'b1;
  // Fast read descriptors
  localparam logic [4:0] FPT_WAIT_144 = 5'h04;
  localparam logic [2:0] FPT_MODE_144 = 3'h2;
  localparam logic [7:0] FPT_OP_144 = 8'heb;
  localparam logic [4:0] FPT_WAIT_114 = 5'h08;
  localparam logic [2:0] FPT_MODE_114 = 3'h0;
  localparam logic [7:0] FPT_OP_114 = 8'h6b;
  localparam logic [4:0] FPT_WAIT_112 = 5'h08;
  localparam logic [2:0] FPT_MODE_112 = 3'h0;
  localparam logic [7:0] FPT_OP_112 = 8'h3b;
  localparam logic [4:0] FPT_WAIT_122 = 5'h00;
  localparam logic [2:0] FPT_MODE_122 = 3'h4;
  localparam logic [7:0] FPT_OP_122 = 8'hbb;
  localparam logic FPT_SUP_222 = 1'b0;
  localparam logic FPT_SUP_444 = 1'b0;
  localparam logic [4:0] FPT_WAIT_NONE = 5'h00;
  localparam logic [2:0] FPT_MODE_NONE = 3'h0;
  localparam logic [7:0] FPT_OP_NONE = 8'hff;
  localparam logic [2:0] FPT_UNUSED_40 = 3'h7;
  // Density, bytes 34H..37H
  localparam logic [31:0] FPT_DENSITY = 32'h03ffffff;
  // Erase types: size exponent and opcode
  localparam logic [7:0] FPT_ET1_SIZE = 8'h0c;
  localparam logic [7:0] FPT_ET1_OP = 8'h20;
  localparam logic [7:0] FPT_ET2_SIZE = 8'h0f;
  localparam logic [7:0] FPT_ET2_OP = 8'h52;
  localparam logic [7:0] FPT_ET3_SIZE = 8'h10;
  localparam logic [7:0] FPT_ET3_OP = 8'hd8;
  localparam logic [7:0] FPT_ET4_SIZE = 8'h08;
  localparam logic [7:0] FPT_ET4_OP = 8'h81;

  typedef struct packed {
    logic start;
    logic [23:0] addr;
    logic sclk_fall;
    logic selected;
  } fpt_req_type;

  typedef struct packed {
    logic so;
    logic so_oe;
    logic rejected;
    logic [7:0] cur_addr;
  } fpt_resp_type;

endpackage : fpt_pkg

/* verilog/fpt_rom.sv */
// Fixed parameter table ROM with its byte sequencer and serial output.
// Assumes the command engine has decoded the table read command, the
// address and dummy byte, and supplies a falling-edge strobe of SCLK.
`timescale 1ns/1ps

// Summary of operation
// - Byte 30H bits 1:0 read 01b: uniform 4 KB erase supported.
// - Byte 30H bit 2 reads 1: write granularity of 64 bytes or more.
// - Byte 30H bits 4:3 read 00b: status bits are nonvolatile.
// - Byte 32H bits 2:1 read 00b: three-byte addressing only.
// - Byte 32H bit 3 reads 0: double transfer rate not supported.
// - Byte 30H bits 7:5 read 111b and nothing can alter them.
// - Quad address and data read: supported, EBH, four waits, mode 010b.
// - Quad output read: supported, 6BH, eight waits, no mode bits.
// - Dual output read: supported, 3BH, eight waits, no mode bits.
// - Dual address and data read: supported, BBH, no waits, mode 100b.
// - All-dual read unsupported: bit 0, zero fields, opcode FFH.
// - All-quad read unsupported: bit 4 of 40H zero, opcode FFH.
// - Erase type one: size code 0CH, opcode 20H.
// - Erase type two: size code 0FH, opcode 52H.
// - Erase type three: size code 10H, opcode D8H.
// - Erase type four: size code 08H, opcode 81H.
// - Bytes leave on falling edges; address increments and wraps to zero.
// - A table read during erase, program or write is rejected harmlessly.
module fpt_rom (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire fpt_pkg::fpt_req_type req,
  input wire logic wip,
  output fpt_pkg::fpt_resp_type resp
);
  import fpt_pkg::*;

  typedef enum logic [1:0] {FPT_IDLE, FPT_SEND, FPT_REJECT} fpt_state_type;

  // Constant table; no write path exists at all
  function automatic logic [7:0] fpt_byte(input logic [FPT_AW-1:0] a);
    logic [7:0] d;
    d = FPT_BLANK;
    unique case (a)
      8'h30: d = {FPT_UNUSED_30, FPT_VOL_WREN_SEL, FPT_VOL_STATUS, FPT_WRITE_GRAN,
                  FPT_ERASE4K_CODE};
      8'h31: d = FPT_ET1_OP;
      8'h32: d = {FPT_UNUSED_32, FPT_SUP_114, FPT_SUP_144, FPT_SUP_122, FPT_SUP_DTR,
                  FPT_ADDR_BYTES, FPT_SUP_112};
      8'h33: d = FPT_BLANK;
      8'h34: d = FPT_DENSITY[7:0];
      8'h35: d = FPT_DENSITY[15:8];
      8'h36: d = FPT_DENSITY[23:16];
      8'h37: d = FPT_DENSITY[31:24];
      8'h38: d = {FPT_MODE_144, FPT_WAIT_144};
      8'h39: d = FPT_OP_144;
      8'h3a: d = {FPT_MODE_114, FPT_WAIT_114};
      8'h3b: d = FPT_OP_114;
      8'h3c: d = {FPT_MODE_112, FPT_WAIT_112};
      8'h3d: d = FPT_OP_112;
      8'h3e: d = {FPT_MODE_122, FPT_WAIT_122};
      8'h3f: d = FPT_OP_122;
      8'h40: d = {FPT_UNUSED_40, FPT_SUP_444, FPT_UNUSED_40, FPT_SUP_222};
      8'h46: d = {FPT_MODE_NONE, FPT_WAIT_NONE};
      8'h47: d = FPT_OP_NONE;
      8'h4a: d = {FPT_MODE_NONE, FPT_WAIT_NONE};
      8'h4b: d = FPT_OP_NONE;
      8'h4c: d = FPT_ET1_SIZE;
      8'h4d: d = FPT_ET1_OP;
      8'h4e: d = FPT_ET2_SIZE;
      8'h4f: d = FPT_ET2_OP;
      8'h50: d = FPT_ET3_SIZE;
      8'h51: d = FPT_ET3_OP;
      8'h52: d = FPT_ET4_SIZE;
      8'h53: d = FPT_ET4_OP;
      default: d = FPT_BLANK;
    endcase
    return d;
  endfunction : fpt_byte

  fpt_state_type state_r;
  fpt_state_type state_nxt;
  logic [FPT_AW-1:0] addr_r;
  logic [FPT_AW-1:0] addr_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic so_r;
  logic so_nxt;
  logic oe_r;
  logic oe_nxt;
  logic rej_r;
  logic rej_nxt;
  logic [FPT_AW-1:0] addr_inc;

  // Wrap past the top address back to zero
  assign addr_inc = (addr_r == FPT_TOP_ADDR) ? '0 : addr_r + 8'h01;

  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    so_nxt = so_r;
    oe_nxt = oe_r;
    rej_nxt = rej_r;
    if (!req.selected)
    begin
      // Deselect ends any read at once
      state_nxt = FPT_IDLE;
      oe_nxt = 1'b0;
      rej_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        FPT_IDLE:
        begin
          if (req.start)
          begin
            // Engine has already taken opcode, address and dummy
            if (wip)
            begin
              state_nxt = FPT_REJECT;
              rej_nxt = 1'b1;
            end
            else
            begin
              state_nxt = FPT_SEND;
              addr_nxt = req.addr[FPT_AW-1:0];
              shift_nxt = fpt_byte(req.addr[FPT_AW-1:0]);
              bit_nxt = FPT_BIT_FIRST;
            end
          end
        end
        FPT_SEND:
        begin
          if (req.sclk_fall)
          begin
            so_nxt = shift_r[7];
            oe_nxt = 1'b1;
            if (bit_r == FPT_BIT_LAST)
            begin
              addr_nxt = addr_inc;
              shift_nxt = fpt_byte(addr_inc);
              bit_nxt = FPT_BIT_FIRST;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              bit_nxt = bit_r - 3'h1;
            end
          end
        end
        FPT_REJECT:
        begin
          // Held off until deselect; busy cycle never sees this read
          oe_nxt = 1'b0;
        end
        default:
        begin
          state_nxt = FPT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_r <= FPT_IDLE;
      addr_r <= '0;
      shift_r <= FPT_BLANK;
      bit_r <= FPT_BIT_FIRST;
      so_r <= 1'b0;
      oe_r <= 1'b0;
      rej_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      so_r <= so_nxt;
      oe_r <= oe_nxt;
      rej_r <= rej_nxt;
    end
  end

  assign resp.so = so_r;
  assign resp.so_oe = oe_r;
  assign resp.rejected = rej_r;
  assign resp.cur_addr = addr_r;

  logic go_ok;
  assign go_ok = req.selected && req.start && !wip && (state_r == FPT_IDLE);

  // Byte reload mid-stream, so table checks other than a_b30_erase, a_b30_gran, a_b30_unused and a_qio also fire on swept bytes
  logic seq_step;
  assign seq_step = req.selected && state_r == FPT_SEND && req.sclk_fall && bit_r == 3'h0;

  property p_b30_erase;
    @(posedge clk_sys) disable iff (!rst_b)
    go_ok && req.addr[7:0] == 8'h30 |=> shift_r[1:0] == 2'b01;
  endproperty
  a_b30_erase: assert property (p_b30_erase) else $error("4KB erase code wrong");

  property p_b30_gran;
    @(posedge clk_sys) disable iff (!rst_b)
    go_ok && req.addr[7:0] == 8'h30 |=> shift_r[2] && shift_r[4:3] == 2'b00;
  endproperty
  a_b30_gran: assert property (p_b30_gran) else $error("granularity or volatility wrong");

  property p_b30_unused;
    @(posedge clk_sys) disable iff (!rst_b)
    go_ok && req.addr[7:0] == 8'h30 |=> shift_r[7:5] == 3'b111 ##0 shift_r == 8'he5;
  endproperty
  a_b30_unused: assert property (p_b30_unused) else $error("byte 30H wrong");

  property p_b32;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h32) || (seq_step && addr_r == 8'h31)
      |=> shift_r[3:1] == 3'b000 && shift_r == 8'hf1;
  endproperty
  a_b32: assert property (p_b32) else $error("byte 32H wrong");

  property p_qio;
    @(posedge clk_sys) disable iff (!rst_b)
    go_ok && req.addr[7:0] == 8'h38 |=> shift_r == 8'h44;
  endproperty
  a_qio: assert property (p_qio) else $error("quad io descriptor wrong");

  property p_dio;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h3e) || (seq_step && addr_r == 8'h3d)
      |=> shift_r == 8'h80;
  endproperty
  a_dio: assert property (p_dio) else $error("dual io descriptor wrong");

  property p_no444;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h40) || (seq_step && addr_r == 8'h3f)
      |=> !shift_r[4] && !shift_r[0];
  endproperty
  a_no444: assert property (p_no444) else $error("unsupported read flagged");

  property p_et1;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h4c) || (seq_step && addr_r == 8'h4b)
      |=> shift_r == 8'h0c;
  endproperty
  a_et1: assert property (p_et1) else $error("erase type one size wrong");

  property p_b30_status;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h30) || (seq_step && addr_r == 8'h2f)
      |=> shift_r[4:3] == 2'b00;
  endproperty
  a_b30_status: assert property (p_b30_status) else $error("volatility bits wrong");

  property p_b32_dtr;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h32) || (seq_step && addr_r == 8'h31)
      |=> !shift_r[3];
  endproperty
  a_b32_dtr: assert property (p_b32_dtr) else $error("double rate flag set");

  property p_qout;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h3a) || (seq_step && addr_r == 8'h39)
      |=> shift_r == 8'h08;
  endproperty
  a_qout: assert property (p_qout) else $error("quad output descriptor wrong");

  property p_dout;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h3c) || (seq_step && addr_r == 8'h3b)
      |=> shift_r == 8'h08;
  endproperty
  a_dout: assert property (p_dout) else $error("dual output descriptor wrong");

  property p_no222;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h46) || (seq_step && addr_r == 8'h45)
      |=> shift_r == 8'h00;
  endproperty
  a_no222: assert property (p_no222) else $error("all-dual descriptor not zero");

  property p_et2;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h4e) || (seq_step && addr_r == 8'h4d)
      |=> shift_r == 8'h0f;
  endproperty
  a_et2: assert property (p_et2) else $error("erase type two size wrong");

  property p_et3;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h50) || (seq_step && addr_r == 8'h4f)
      |=> shift_r == 8'h10;
  endproperty
  a_et3: assert property (p_et3) else $error("erase type three size wrong");

  property p_et4;
    @(posedge clk_sys) disable iff (!rst_b)
    (go_ok && req.addr[7:0] == 8'h52) || (seq_step && addr_r == 8'h51)
      |=> shift_r == 8'h08;
  endproperty
  a_et4: assert property (p_et4) else $error("erase type four size wrong");

  property p_shift;
    @(posedge clk_sys) disable iff (!rst_b)
    req.selected && state_r == FPT_SEND && req.sclk_fall
      |=> so_r == $past(shift_r[7]) && oe_r;
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted");

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
    req.selected && state_r == FPT_SEND && req.sclk_fall && bit_r == 3'h0
      && addr_r == 8'hff |=> addr_r == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_reject;
    @(posedge clk_sys) disable iff (!rst_b)
    req.selected && req.start && wip && state_r == FPT_IDLE
      |=> rej_r && !oe_r ##1 (!req.selected || !oe_r);
  endproperty
  a_reject: assert property (p_reject) else $error("busy read not rejected");

endmodule : fpt_rom

/* tb/fpt_host.sv */
// Host controller model issuing table reads to the parameter ROM.
// Assumes the bench owns clk_sys and calls these tasks from one process.
`timescale 1ns/1ps

module fpt_host (
  input wire logic clk_sys,
  output fpt_pkg::fpt_req_type req,
  input wire fpt_pkg::fpt_resp_type resp
);
  import fpt_pkg::*;

  initial req = '0;

  // Opcode, address and dummy already shifted in; start marks their end
  task automatic open_read(input logic [23:0] a);
    @(posedge clk_sys);
    req.selected <= 1'b1;
    req.start <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys);
    req.start <= 1'b0;
    // Stale address inverted so it cannot pass for a live one
    req.addr <= ~a;
  endtask : open_read

  // Eight falls per byte, MSB first; gap 0 keeps the strobe high throughout
  task automatic read_byte(input int gap, output logic [7:0] d, output logic oe_all);
    oe_all = 1'b1;
    @(posedge clk_sys);
    req.sclk_fall <= 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_sys);
      if (gap > 0 || i == 0)
        req.sclk_fall <= 1'b0;
      #1;
      d[i] = resp.so;
      oe_all = oe_all & resp.so_oe;
      if (gap > 0 && i > 0)
      begin
        repeat (gap) @(posedge clk_sys);
        req.sclk_fall <= 1'b1;
      end
    end
  endtask : read_byte

  task automatic close_read;
    @(posedge clk_sys);
    req.selected <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : close_read

endmodule : fpt_host

/* tb/fpt_rom_tb.sv */
// Self-checking bench for the parameter table ROM.
// Assumes the host model in fpt_host drives every request field.
`timescale 1ns/1ps

module fpt_rom_tb;
  import fpt_pkg::*;

  logic clk_sys;
  logic rst_b;
  logic wip;
  fpt_req_type req;
  fpt_resp_type resp;
  int miscompares;
  int num_checks;

  localparam logic [7:0] EXP_TAB [36] = '{
    8'he5, 8'h20, 8'hf1, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h44, 8'heb, 8'h08, 8'h6b,
    8'h08, 8'h3b, 8'h80, 8'hbb, 8'hee, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
    8'hff, 8'hff, 8'h00, 8'hff, 8'h0c, 8'h20, 8'h0f, 8'h52, 8'h10, 8'hd8, 8'h08, 8'h81};

  fpt_rom uut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .wip(wip), .resp(resp));
  fpt_host host (.clk_sys(clk_sys), .req(req), .resp(resp));

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    // Outside the window every byte reads blank
    return (a >= 8'h30 && a <= 8'h53) ? EXP_TAB[a - 8'h30] : 8'hff;
  endfunction : exp_byte

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d, wrong values %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic run_bytes(input logic [7:0] a, input int n, input int gap);
    logic [7:0] d;
    logic oe;
    for (int k = 0; k < n; k++)
    begin
      // One spare edge so a late address update is not misjudged
      @(posedge clk_sys);
      #1;
      check(resp.cur_addr, a, "address");
      host.read_byte(gap, d, oe);
      check({7'h00, oe}, 8'h01, "drive");
      check(d, exp_byte(a), "table byte");
      a++;
    end
  endtask : run_bytes

  task automatic sc_sweep;
    host.open_read(24'h00002e);
    run_bytes(8'h2e, 40, 2);
    host.close_read();
    check({7'h00, resp.so_oe}, 8'h00, "release");
  endtask : sc_sweep

  task automatic sc_wrap;
    // Second pass over 30H..33H also shows the contents did not move
    // Upper address bytes set on purpose; only the low byte selects
    host.open_read(24'h0100fe);
    run_bytes(8'hfe, 54, 0);
    host.close_read();
  endtask : sc_wrap

  task automatic sc_busy;
    logic [7:0] d;
    logic oe;
    @(posedge clk_sys);
    wip <= 1'b1;
    host.open_read(24'h000030);
    @(posedge clk_sys);
    wip <= 1'b0;
    #1;
    check({7'h00, resp.rejected}, 8'h01, "refusal");
    host.read_byte(1, d, oe);
    check({7'h00, resp.so_oe}, 8'h00, "quiet");
    host.close_read();
    check({7'h00, resp.rejected}, 8'h00, "refusal clear");
    host.open_read(24'h000030);
    run_bytes(8'h30, 2, 1);
    host.close_read();
  endtask : sc_busy

  task automatic sc_abort;
    // Byte 39H ends on a one, so a reset that missed SO would show
    host.open_read(24'h000039);
    run_bytes(8'h39, 1, 0);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    check({resp.so_oe, resp.rejected, resp.so, 5'h00}, 8'h00, "reset outputs");
    check(resp.cur_addr, 8'h00, "reset address");
    host.close_read();
    host.open_read(24'h000053);
    run_bytes(8'h53, 2, 0);
    host.close_read();
    check({7'h00, resp.so_oe}, 8'h00, "release");
  endtask : sc_abort

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst_b = 1'b0;
    wip = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    sc_sweep();
    sc_wrap();
    sc_busy();
    sc_abort();
    finish_test();
  end

  // Hang guard; a run this long means a stuck sequence
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end

endmodule : fpt_rom_tb
